// File: shared/dbw_pkg.sv
// Shared types, mode fields and timing counts for the DDR3 burst link
package dbw_pkg;
   typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_MRS} cmd_t;
   typedef logic [5:0] cyc_t;

   localparam int BANK_N = 8;
   localparam int COL_W = 10;
   localparam int MEM_DEPTH = 256;
   localparam int SLOT_N = 32;
   localparam int A_BL_OTF = 12;
   localparam int A_TDQS = 11;
   localparam int A_ALL = 10;
   localparam int MR0_BL_LSB = 0;
   localparam int MR0_CL_LSB = 4;
   localparam int MR1_AL_LSB = 3;
   localparam int MR2_CWL_LSB = 3;
   localparam logic [1:0] BL_FIX8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_FIX4 = 2'h2;
   localparam logic [1:0] AL_CL1 = 2'h1;
   localparam logic [1:0] AL_CL2 = 2'h2;
   localparam logic [13:0] MR0_RST = 14'h0020;
   localparam logic [13:0] MR1_RST = 14'h0000;
   localparam logic [13:0] MR2_RST = 14'h0000;
   localparam cyc_t CL_BASE = 6'h04;
   localparam cyc_t CWL_BASE = 6'h05;
   localparam cyc_t BL8_CK = 6'h04;
   localparam cyc_t BC4_CK = 6'h02;
   localparam cyc_t CCD_CK = 6'h04;
   localparam cyc_t TURN_CK = 6'h02;
   localparam cyc_t RTP_NCK = 6'h04;
   localparam cyc_t WTR_NCK = 6'h04;
   localparam cyc_t ONE_NCK = 6'h01;
   localparam logic [2:0] RST_HOLD_CK = 3'h4;

   localparam int CK_DIV = 2;
   localparam real CLK_NS = 5.0;
   localparam real CK_NS = CLK_NS * CK_DIV;
   localparam real T_RTP_NS = 7.5;
   localparam real T_RP_NS = 15.0;
   localparam real T_RAS_NS = 37.5;
   localparam real T_RC_NS = 52.5;
   localparam real T_WR_NS = 15.0;
   localparam real T_WTR_NS = 7.5;

   // Least time in CK cycles, rounded up, never below minNck
   function automatic cyc_t ckMin(input real ns, input cyc_t minNck);
      int n;
      n = int'($ceil(ns / CK_NS));
      return (cyc_t'(n) > minNck) ? cyc_t'(n) : minNck;
   endfunction : ckMin

   localparam cyc_t RTP_CK = ckMin(T_RTP_NS, RTP_NCK);
   localparam cyc_t RP_CK = ckMin(T_RP_NS, ONE_NCK);
   localparam cyc_t RAS_CK = ckMin(T_RAS_NS, ONE_NCK);
   localparam cyc_t RC_CK = ckMin(T_RC_NS, ONE_NCK);
   localparam cyc_t WR_CK = ckMin(T_WR_NS, ONE_NCK);
   localparam cyc_t WTR_CK = ckMin(T_WTR_NS, WTR_NCK);

   function automatic logic isBurst8(input logic [13:0] mr0, input logic a12);
      case (mr0[MR0_BL_LSB +: 2])
         BL_FIX4: return 1'b0;
         BL_OTF:  return a12;
         default: return 1'b1;
      endcase
   endfunction : isBurst8

   function automatic cyc_t burstCk(input logic b8);
      return b8 ? BL8_CK : BC4_CK;
   endfunction : burstCk

   function automatic cyc_t casLat(input logic [13:0] mr0);
      return CL_BASE + {3'h0, mr0[MR0_CL_LSB +: 3]};
   endfunction : casLat

   function automatic cyc_t addLat(input logic [13:0] mr0, input logic [13:0] mr1);
      case (mr1[MR1_AL_LSB +: 2])
         AL_CL1:  return casLat(mr0) - 6'h01;
         AL_CL2:  return casLat(mr0) - 6'h02;
         default: return 6'h00;
      endcase
   endfunction : addLat

   function automatic cyc_t readLat(input logic [13:0] mr0, input logic [13:0] mr1);
      return addLat(mr0, mr1) + casLat(mr0);
   endfunction : readLat

   function automatic cyc_t writeLat(input logic [13:0] mr0, input logic [13:0] mr1, input logic [13:0] mr2);
      return addLat(mr0, mr1) + CWL_BASE + {3'h0, mr2[MR2_CWL_LSB +: 3]};
   endfunction : writeLat

   // Down counter that a new load can only lengthen
   function automatic cyc_t holdOff(input cyc_t cnt, input cyc_t load);
      cyc_t d;
      d = (cnt != 6'h00) ? cnt - 6'h01 : 6'h00;
      return (load > d) ? load : d;
   endfunction : holdOff
endpackage : dbw_pkg

// File: shared/dbw_if.sv
// Link between memory controller and memory device
`timescale 1ns/1ps
interface dbw_if;
   logic            ck;
   logic            rstN;
   dbw_pkg::cmd_t   cmd;
   logic [2:0]      ba;
   logic [13:0]     addr;
   logic [15:0]     dqW;
   logic [1:0]      dmW;
   logic            dqsW;
   logic [15:0]     dqR;
   logic            dqsR;

   modport ctrl (
      output ck, rstN, cmd, ba, addr, dqW, dmW, dqsW,
      input  dqR, dqsR
   );
   modport dev (
      input  ck, rstN, cmd, ba, addr, dqW, dmW, dqsW,
      output dqR, dqsR
   );
endinterface : dbw_if

// File: hdl/dbw_device.sv
// Device end: command decode, burst scheduling, byte store and misuse checks
`timescale 1ns/1ps
// Summary of operation
// - Read to precharge waits AL plus tRTP
// - tRTP at least 4 cycles and 7.5 ns
// - Activate only after tRP and tRC; the device flags only an activate to an open bank
// - A12 picks chop 4 or burst 8
// - A12 never used as column bit
// - Burst field 00 fixed 8, 01 selectable
// - Burst field 10 forces chop 4
// - Write to read counted after last beat
// - Write recovery counted after last beat; the device precharge guard ends at the last beat, with no tWR added
// - Timing violation recovered by full reset
// - Data timing faults hit addressed bytes only
// - Strobe timing faults never hang device
// - One mask per byte blocks store
// - Mask ignored on reads and TDQS mode
module dbw_device (
   dbw_if.dev               link,      // Memory link
   input  wire logic        clkEn,     // Clock enable
   output logic             busy,      // Burst pending
   output logic [7:0]       bankOpen,  // Open banks
   output logic             fault      // Sticky misuse flag
);
   typedef struct packed {
      logic       wr;
      logic       b8;
      logic [2:0] ba;
      logic [9:0] col;
   } dbw_slot_t;

   logic [13:0]         mr0;
   logic [13:0]         mr1;
   logic [13:0]         mr2;
   logic                isRd;
   logic                isWr;
   logic                isRw;
   logic                isAct;
   logic                isPre;
   dbw_slot_t           cmdSlot;
   dbw_pkg::cyc_t       lat;
   dbw_pkg::cyc_t       bc;
   dbw_pkg::cyc_t       al;
   logic [4:0]          tPtr;
   logic [4:0]          slotIdx;
   logic [31:0]         slotVld;
   dbw_slot_t           slot [dbw_pkg::SLOT_N];
   logic                startHit;
   logic                actV;
   logic                lastBeat;
   dbw_slot_t           cur;
   logic [1:0]          aBeat;
   logic                engOn;
   dbw_slot_t           eng;
   logic [1:0]          engBeat;
   logic [7:0]          mem [dbw_pkg::MEM_DEPTH];
   logic [7:0]          memIdx [2];
   dbw_pkg::cyc_t       ccdCnt;
   dbw_pkg::cyc_t       wtrCnt;
   logic [7:0]          preBad;
   logic                rwBad;
   logic                actBad;
   logic                strobeBad;

   assign isRd = link.cmd == dbw_pkg::CMD_RD;
   assign isWr = link.cmd == dbw_pkg::CMD_WR;
   assign isRw = isRd | isWr;
   assign isAct = link.cmd == dbw_pkg::CMD_ACT;
   assign isPre = link.cmd == dbw_pkg::CMD_PRE;

   // Burst length per command from the mode field and A12
   always_comb begin
      cmdSlot.wr = isWr;
      cmdSlot.b8 = dbw_pkg::isBurst8(mr0, link.addr[dbw_pkg::A_BL_OTF]);
      cmdSlot.ba = link.ba;
      cmdSlot.col = link.addr[dbw_pkg::COL_W-1:0];
   end

   assign al = dbw_pkg::addLat(mr0, mr1);
   assign bc = dbw_pkg::burstCk(cmdSlot.b8);
   assign lat = isWr ? dbw_pkg::writeLat(mr0, mr1, mr2) : dbw_pkg::readLat(mr0, mr1);
   assign slotIdx = tPtr + lat[4:0];

   always_ff @(posedge link.ck) begin
      if (!link.rstN) begin
         mr0 <= dbw_pkg::MR0_RST;
         mr1 <= dbw_pkg::MR1_RST;
         mr2 <= dbw_pkg::MR2_RST;
      end else if (clkEn && link.cmd == dbw_pkg::CMD_MRS) begin
         case (link.ba[1:0])
            2'h0:    mr0 <= link.addr;
            2'h1:    mr1 <= link.addr;
            2'h2:    mr2 <= link.addr;
            default: ;
         endcase
      end
   end

   // Timeline of future burst starts; a slot is read when the pointer reaches it
   always_ff @(posedge link.ck) begin
      if (!link.rstN) begin
         tPtr <= 5'h00;
         slotVld <= 32'h0000_0000;
      end else if (clkEn) begin
         tPtr <= tPtr + 5'h01;
         slotVld[tPtr] <= 1'b0;
         if (isRw && !rwBad) begin
            slotVld[slotIdx] <= 1'b1;
         end
      end
   end

   always_ff @(posedge link.ck) begin
      if (clkEn && isRw) begin
         slot[slotIdx] <= cmdSlot;
      end
   end

   always_comb begin
      startHit = slotVld[tPtr];
      cur = startHit ? slot[tPtr] : eng;
      aBeat = startHit ? 2'h0 : engBeat;
      actV = startHit | engOn;
      lastBeat = aBeat == (cur.b8 ? 2'h3 : 2'h1);
   end

   // Byte column inside the burst, wrapping in 8 or in 4
   function automatic logic [4:0] colAt(input logic [9:0] col, input logic b8, input logic [2:0] pos);
      logic [2:0] s8;
      logic [1:0] s4;
      s8 = col[2:0] + pos;
      s4 = col[1:0] + pos[1:0];
      return b8 ? {col[4:3], s8} : {col[4:2], s4};
   endfunction : colAt

   for (genvar k = 0; k < 2; k++) begin : g_lane
      assign memIdx[k] = {cur.ba, colAt(cur.col, cur.b8, {aBeat, 1'(k)})};
   end

   // The engine always stops after its beat count, whatever the strobes did
   always_ff @(posedge link.ck) begin
      if (!link.rstN) begin
         engOn <= 1'b0;
         engBeat <= 2'h0;
         eng <= '0;
      end else if (clkEn) begin
         engOn <= actV && !lastBeat;
         if (actV) begin
            eng <= cur;
            engBeat <= aBeat + 2'h1;
         end
      end
   end

   // Writes land only at the burst's own bytes
   always_ff @(posedge link.ck) begin
      if (clkEn && actV && cur.wr && link.dqsW) begin
         for (int i = 0; i < 2; i++) begin
            if (mr1[dbw_pkg::A_TDQS] || !link.dmW[i]) begin
               mem[memIdx[i]] <= link.dqW[8*i +: 8];
            end
         end
      end
   end

   always_ff @(posedge link.ck) begin
      if (!link.rstN) begin
         link.dqsR <= 1'b0;
         link.dqR <= 16'h0000;
      end else if (clkEn) begin
         link.dqsR <= actV && !cur.wr;
         if (actV && !cur.wr) begin
            link.dqR <= {mem[memIdx[1]], mem[memIdx[0]]};
         end
      end
   end

   // Bank state and precharge guards in CK cycles
   for (genvar b = 0; b < dbw_pkg::BANK_N; b++) begin : g_bank
      logic          hit;
      logic          open;
      dbw_pkg::cyc_t guard;
      dbw_pkg::cyc_t ld;
      assign hit = link.ba == 3'(b);
      always_comb begin
         ld = 6'h00;
         if (hit && isRd) begin
            ld = al + dbw_pkg::RTP_NCK - 6'h01;
         end else if (hit && isWr) begin
            ld = lat + bc - 6'h01;
         end
      end
      always_ff @(posedge link.ck) begin
         if (!link.rstN) begin
            open <= 1'b0;
            guard <= 6'h00;
         end else if (clkEn) begin
            guard <= dbw_pkg::holdOff(guard, ld);
            if (isAct && hit) begin
               open <= 1'b1;
            end else if (isPre && (hit || link.addr[dbw_pkg::A_ALL])) begin
               open <= 1'b0;
            end
         end
      end
      assign bankOpen[b] = open;
      assign preBad[b] = isPre && (hit || link.addr[dbw_pkg::A_ALL]) && guard != 6'h00;
   end

   always_ff @(posedge link.ck) begin
      if (!link.rstN) begin
         ccdCnt <= 6'h00;
         wtrCnt <= 6'h00;
      end else if (clkEn) begin
         ccdCnt <= dbw_pkg::holdOff(ccdCnt, isRw ? dbw_pkg::CCD_CK - 6'h01 : 6'h00);
         wtrCnt <= dbw_pkg::holdOff(wtrCnt, isWr ? lat + bc + dbw_pkg::WTR_NCK - 6'h01 : 6'h00);
      end
   end

   assign rwBad = isRw && (!bankOpen[link.ba] || ccdCnt != 6'h00 || (isRd && wtrCnt != 6'h00));
   assign actBad = isAct && bankOpen[link.ba];
   assign strobeBad = actV && cur.wr && !link.dqsW;

   // Misuse is reported and a bad read or write is not scheduled; recovery is a reset from the link
   always_ff @(posedge link.ck) begin
      if (!link.rstN) begin
         fault <= 1'b0;
      end else if (clkEn && (rwBad || actBad || strobeBad || preBad != 8'h00)) begin
         fault <= 1'b1;
      end
   end

   assign busy = engOn | (slotVld != 32'h0000_0000);
endmodule : dbw_device

// File: hdl/dbw_ctrl.sv
// Controller end: CK divider, command spacing and burst data movement
`timescale 1ns/1ps
module dbw_ctrl (
   input  wire logic          clock,     // System clock
   input  wire logic          nrst,      // Sync reset, low
   input  wire logic          clkEn,     // Clock enable
   dbw_if.ctrl                link,      // Memory link
   input  wire logic          reqValid,  // Command request
   output logic               reqReady,  // Command accepted
   input  wire dbw_pkg::cmd_t reqOp,     // Command code
   input  wire logic [2:0]    reqBank,   // Bank or mode register
   input  wire logic [13:0]   reqAddr,   // Row, column or mode value
   input  wire logic [63:0]   wrData,    // Write bytes, byte 0 first
   input  wire logic [7:0]    wrMask,    // Byte masks, high drops
   output logic [63:0]        rdData,    // Read bytes, byte 0 first
   output logic               rdValid    // Read done pulse
);
   logic                ckDiv;
   logic                tick;
   logic [2:0]          holdCnt;
   logic [13:0]         mr0;
   logic [13:0]         mr1;
   logic [13:0]         mr2;
   logic                allowed;
   logic                take;
   dbw_pkg::cyc_t       bc;
   dbw_pkg::cyc_t       rl;
   dbw_pkg::cyc_t       wl;
   dbw_pkg::cyc_t       al;
   logic [7:0]          preZero;
   logic [7:0]          actZero;
   dbw_pkg::cyc_t       ccdCnt;
   dbw_pkg::cyc_t       wtrCnt;
   dbw_pkg::cyc_t       rtwCnt;
   logic                wrBusy;
   dbw_pkg::cyc_t       wrPh;
   dbw_pkg::cyc_t       wrLat;
   dbw_pkg::cyc_t       wrBc;
   dbw_pkg::cyc_t       wrBeat;
   logic [63:0]         wrBuf;
   logic [7:0]          wrMsk;
   logic                rdBusy;
   logic                rdDone;
   dbw_pkg::cyc_t       rdPh;
   dbw_pkg::cyc_t       rdLat;
   dbw_pkg::cyc_t       rdBc;
   dbw_pkg::cyc_t       rdBeat;
   logic [63:0]         rdBuf;

   // CK is clock divided by two; the tick is the clock edge where CK falls
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ckDiv <= 1'b0;
      end else if (clkEn) begin
         ckDiv <= ~ckDiv;
      end
   end
   assign link.ck = ckDiv;
   assign tick = clkEn & ckDiv;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         holdCnt <= dbw_pkg::RST_HOLD_CK;
         link.rstN <= 1'b0;
      end else if (tick) begin
         if (holdCnt != 3'h0) begin
            holdCnt <= holdCnt - 3'h1;
         end
         link.rstN <= holdCnt == 3'h0;
      end
   end

   assign bc = dbw_pkg::burstCk(dbw_pkg::isBurst8(mr0, reqAddr[dbw_pkg::A_BL_OTF]));
   assign rl = dbw_pkg::readLat(mr0, mr1);
   assign wl = dbw_pkg::writeLat(mr0, mr1, mr2);
   assign al = dbw_pkg::addLat(mr0, mr1);

   always_comb begin
      case (reqOp)
         dbw_pkg::CMD_NOP: allowed = 1'b1;
         dbw_pkg::CMD_ACT: allowed = actZero[reqBank];
         dbw_pkg::CMD_PRE: allowed = reqAddr[dbw_pkg::A_ALL] ? (&preZero) : preZero[reqBank];
         dbw_pkg::CMD_RD:  allowed = ccdCnt == 6'h00 && wtrCnt == 6'h00 && !rdBusy;
         dbw_pkg::CMD_WR:  allowed = ccdCnt == 6'h00 && rtwCnt == 6'h00 && !wrBusy;
         dbw_pkg::CMD_MRS: allowed = !rdBusy && !wrBusy;
         default:          allowed = 1'b0;
      endcase
   end
   assign reqReady = tick & link.rstN & allowed;
   assign take = reqValid & reqReady;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         link.cmd <= dbw_pkg::CMD_NOP;
         link.ba <= 3'h0;
         link.addr <= 14'h0000;
      end else if (tick) begin
         link.cmd <= take ? reqOp : dbw_pkg::CMD_NOP;
         if (take) begin
            link.ba <= reqBank;
            link.addr <= reqAddr;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         mr0 <= dbw_pkg::MR0_RST;
         mr1 <= dbw_pkg::MR1_RST;
         mr2 <= dbw_pkg::MR2_RST;
      end else if (take && reqOp == dbw_pkg::CMD_MRS) begin
         case (reqBank[1:0])
            2'h0:    mr0 <= reqAddr;
            2'h1:    mr1 <= reqAddr;
            2'h2:    mr2 <= reqAddr;
            default: ;
         endcase
      end
   end

   for (genvar b = 0; b < dbw_pkg::BANK_N; b++) begin : g_bank
      logic          hit;
      logic          allPre;
      dbw_pkg::cyc_t preCnt;
      dbw_pkg::cyc_t actCnt;
      dbw_pkg::cyc_t preLd;
      dbw_pkg::cyc_t actLd;
      assign hit = take && reqBank == 3'(b);
      assign allPre = take && reqOp == dbw_pkg::CMD_PRE && reqAddr[dbw_pkg::A_ALL];
      always_comb begin
         preLd = 6'h00;
         actLd = 6'h00;
         if (hit && reqOp == dbw_pkg::CMD_ACT) begin
            preLd = dbw_pkg::RAS_CK - 6'h01;
            actLd = dbw_pkg::RC_CK - 6'h01;
         end else if (hit && reqOp == dbw_pkg::CMD_RD) begin
            preLd = al + dbw_pkg::RTP_CK - 6'h01;
         end else if (hit && reqOp == dbw_pkg::CMD_WR) begin
            preLd = wl + bc + dbw_pkg::WR_CK - 6'h01;
         end else if ((hit || allPre) && reqOp == dbw_pkg::CMD_PRE) begin
            actLd = dbw_pkg::RP_CK - 6'h01;
         end
      end
      always_ff @(posedge clock) begin
         if (!nrst) begin
            preCnt <= 6'h00;
            actCnt <= 6'h00;
         end else if (tick) begin
            preCnt <= dbw_pkg::holdOff(preCnt, preLd);
            actCnt <= dbw_pkg::holdOff(actCnt, actLd);
         end
      end
      assign preZero[b] = preCnt == 6'h00;
      assign actZero[b] = actCnt == 6'h00;
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         ccdCnt <= 6'h00;
         wtrCnt <= 6'h00;
         rtwCnt <= 6'h00;
      end else if (tick) begin
         ccdCnt <= dbw_pkg::holdOff(ccdCnt,
            (take && (reqOp == dbw_pkg::CMD_RD || reqOp == dbw_pkg::CMD_WR)) ? dbw_pkg::CCD_CK - 6'h01 : 6'h00);
         wtrCnt <= dbw_pkg::holdOff(wtrCnt,
            (take && reqOp == dbw_pkg::CMD_WR) ? wl + bc + dbw_pkg::WTR_CK - 6'h01 : 6'h00);
         rtwCnt <= dbw_pkg::holdOff(rtwCnt,
            (take && reqOp == dbw_pkg::CMD_RD && rl + bc + dbw_pkg::TURN_CK > wl) ?
            rl + bc + dbw_pkg::TURN_CK - wl - 6'h01 : 6'h00);
      end
   end

   // Beat pair i goes out on the tick before CK edge WL+i
   assign wrBeat = wrPh - wrLat;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         wrBusy <= 1'b0;
         wrPh <= 6'h00;
         wrLat <= 6'h00;
         wrBc <= 6'h00;
         wrBuf <= 64'h0000_0000_0000_0000;
         wrMsk <= 8'h00;
         link.dqsW <= 1'b0;
         link.dqW <= 16'h0000;
         link.dmW <= 2'h0;
      end else if (tick) begin
         if (take && reqOp == dbw_pkg::CMD_WR) begin
            wrBusy <= 1'b1;
            wrPh <= 6'h01;
            wrLat <= wl;
            wrBc <= bc;
            wrBuf <= wrData;
            wrMsk <= wrMask;
         end else if (wrBusy) begin
            wrPh <= wrPh + 6'h01;
         end
         if (wrBusy && wrPh >= wrLat) begin
            link.dqsW <= 1'b1;
            link.dqW <= wrBuf[{wrBeat[1:0], 4'h0} +: 16];
            link.dmW <= wrMsk[{wrBeat[1:0], 1'b0} +: 2];
            if (wrBeat == wrBc - 6'h01) begin
               wrBusy <= 1'b0;
            end
         end else begin
            link.dqsW <= 1'b0;
         end
      end
   end

   // Beat pair i is sampled on the tick after CK edge RL+i
   assign rdBeat = rdPh - rdLat;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rdBusy <= 1'b0;
         rdDone <= 1'b0;
         rdPh <= 6'h00;
         rdLat <= 6'h00;
         rdBc <= 6'h00;
         rdBuf <= 64'h0000_0000_0000_0000;
         rdData <= 64'h0000_0000_0000_0000;
         rdValid <= 1'b0;
      end else if (clkEn) begin
         rdValid <= rdDone;
         rdDone <= 1'b0;
         if (rdDone) begin
            rdData <= rdBuf;
         end
         if (tick && take && reqOp == dbw_pkg::CMD_RD) begin
            rdBusy <= 1'b1;
            rdPh <= 6'h01;
            rdLat <= rl + 6'h01;
            rdBc <= bc;
            rdBuf <= 64'h0000_0000_0000_0000;
         end else if (tick && rdBusy) begin
            rdPh <= rdPh + 6'h01;
            if (rdPh >= rdLat) begin
               rdBuf[{rdBeat[1:0], 4'h0} +: 16] <= link.dqR;
               if (rdBeat == rdBc - 6'h01) begin
                  rdBusy <= 1'b0;
                  rdDone <= 1'b1;
               end
            end
         end
      end
   end
endmodule : dbw_ctrl

// File: tb/dbw_link_properties.sv
// Timing checks on the link between controller and device
`timescale 1ns/1ps
module dbw_link_properties (
   input wire logic          ck,    // Link clock
   input wire logic          rstN,  // Link reset, low
   input wire dbw_pkg::cmd_t cmd,   // Command
   input wire logic [2:0]    ba,    // Bank or mode register
   input wire logic [13:0]   addr,  // Address
   input wire logic          dqsW,  // Write beats valid
   input wire logic          dqsR   // Read beats valid
);
   logic [1:0] bl;
   logic       b8;
   logic       rw;
   default clocking @(posedge ck); endclocking
   default disable iff (!rstN);
   // Copy of the burst field written by mode register 0 loads
   always_ff @(posedge ck) begin
      if (!rstN) bl <= dbw_pkg::BL_FIX8;
      else if (cmd == dbw_pkg::CMD_MRS && ba == 3'h0) bl <= addr[dbw_pkg::MR0_BL_LSB +: 2];
   end
   assign b8 = (bl == dbw_pkg::BL_FIX4) ? 1'b0 : (bl == dbw_pkg::BL_OTF) ? addr[dbw_pkg::A_BL_OTF] : 1'b1;
   assign rw = cmd == dbw_pkg::CMD_RD || cmd == dbw_pkg::CMD_WR;
   sequence wrLong; ##5 dqsW [*4]; endsequence
   sequence wrShort; ##5 dqsW [*2] ##1 !dqsW [*2]; endsequence
   sequence rdLong; ##7 dqsR [*4]; endsequence
   sequence rdShort; ##7 dqsR [*2] ##1 !dqsR; endsequence
   AST_WR_BL8: assert property (cmd == dbw_pkg::CMD_WR && b8 |-> wrLong)
      else $error("write burst of eight misplaced");
   AST_WR_BC4: assert property (cmd == dbw_pkg::CMD_WR && !b8 |-> wrShort)
      else $error("chopped write burst misplaced");
   AST_RD_BL8: assert property (cmd == dbw_pkg::CMD_RD && b8 |-> rdLong)
      else $error("read burst of eight misplaced");
   AST_RD_BC4: assert property (cmd == dbw_pkg::CMD_RD && !b8 |-> rdShort)
      else $error("chopped read burst misplaced");
   AST_CCD: assert property (rw |=> !rw [*3])
      else $error("column commands too close");
   AST_RTP: assert property (cmd == dbw_pkg::CMD_RD |=> (cmd != dbw_pkg::CMD_PRE) [*3])
      else $error("precharge too soon after read");
   AST_WR_PRE: assert property (cmd == dbw_pkg::CMD_WR |=> (cmd != dbw_pkg::CMD_PRE) [*8])
      else $error("precharge inside write recovery");
   AST_WTR: assert property (cmd == dbw_pkg::CMD_WR |=> (cmd != dbw_pkg::CMD_RD) [*8])
      else $error("read too soon after write");
   AST_RAS: assert property (cmd == dbw_pkg::CMD_ACT |=> (cmd != dbw_pkg::CMD_PRE) [*3])
      else $error("precharge too soon after activate");
   AST_RC: assert property (cmd == dbw_pkg::CMD_ACT |=> (cmd != dbw_pkg::CMD_ACT) [*5])
      else $error("activate inside row cycle");
   AST_RP: assert property (cmd == dbw_pkg::CMD_PRE |=> cmd != dbw_pkg::CMD_ACT)
      else $error("activate inside row precharge");
endmodule : dbw_link_properties

// File: tb/ddr3_burst_write_precharge_timing_tb_top.sv
// Bench joining controller and device: burst modes, masks and timing
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin failCount++; $display("wrong value at %0t: mismatch", $time); end end
module ddr3_burst_write_precharge_timing_tb_top;
   logic          clock = 1'b0;
   logic          nrst = 1'b0;
   logic          clkEn = 1'b1;
   logic          reqValid = 1'b0;
   dbw_pkg::cmd_t reqOp = dbw_pkg::CMD_NOP;
   logic [2:0]    reqBank = 3'h0;
   logic [13:0]   reqAddr = 14'h0000;
   logic [63:0]   wrData = 64'h0000_0000_0000_0000;
   logic [7:0]    wrMask = 8'h00;
   logic [63:0]   rdData;
   logic [63:0]   expD;
   logic [7:0]    bankOpen;
   logic          reqReady;
   logic          rdValid;
   logic          busy;
   logic          fault;
   logic [7:0]    mdl [8];
   logic [63:0]   expQ [$];
   logic [31:0]   seed = 32'h0000_6a54;
   int            failCount = 0;
   int            nTests = 0;
   dbw_if lnk ();
   dbw_ctrl dbw_ctrl_i (.clock(clock), .nrst(nrst), .clkEn(clkEn), .link(lnk.ctrl), .reqValid(reqValid),
      .reqReady(reqReady), .reqOp(reqOp), .reqBank(reqBank), .reqAddr(reqAddr), .wrData(wrData),
      .wrMask(wrMask), .rdData(rdData), .rdValid(rdValid));
   dbw_device dbw_device_i (.link(lnk.dev), .clkEn(clkEn), .busy(busy), .bankOpen(bankOpen), .fault(fault));
   dbw_link_properties dbw_link_properties_i (.ck(lnk.ck), .rstN(lnk.rstN), .cmd(lnk.cmd), .ba(lnk.ba),
      .addr(lnk.addr), .dqsW(lnk.dqsW), .dqsR(lnk.dqsR));
   initial begin
      forever #2.5 clock = ~clock;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic closeOut();
      $display("mismatches %0d, comparisons %0d", failCount, nTests);
      if (failCount == 0 && nTests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : closeOut
   // Holds the request until the controller takes it
   task automatic req(input dbw_pkg::cmd_t op, input logic [2:0] bk, input logic [13:0] ad);
      int n;
      @(negedge clock);
      reqValid = 1'b1;
      reqOp = op;
      reqBank = bk;
      reqAddr = ad;
      #1;
      n = 0;
      while (reqReady !== 1'b1 && n < 400) begin
         @(negedge clock);
         #1;
         n++;
      end
      if (n == 400) begin
         failCount++;
         $display("wrong value at %0t: request not taken", $time);
         closeOut();
      end
      @(negedge clock);
      reqValid = 1'b0;
   endtask : req
   always @(negedge clock) begin
      if (rdValid === 1'b1) `CHK(rdData, expQ.pop_front())
   end
   initial begin
      int n;
      logic b8;
      logic [1:0] bl;
      repeat (16) @(negedge clock);
      nrst = 1'b1;
      req(dbw_pkg::CMD_ACT, 3'h0, 14'h0005);
      // Steps: fixed 8, select 4, select 8, fixed 4 with A12 high, fixed 8 with mask as strobe
      for (int k = 0; k < 5; k++) begin
         bl = (k == 3) ? dbw_pkg::BL_FIX4 : (k == 1 || k == 2) ? dbw_pkg::BL_OTF : dbw_pkg::BL_FIX8;
         b8 = k != 1 && k != 3;
         if (k == 4) req(dbw_pkg::CMD_MRS, 3'h1, 14'h0800);
         req(dbw_pkg::CMD_MRS, 3'h0, dbw_pkg::MR0_RST | 14'(bl));
         wrData = {rnd(), rnd()};
         wrMask = (k == 0) ? 8'h00 : 8'(rnd());
         expD = 64'h0000_0000_0000_0000;
         for (int i = 0; i < (b8 ? 8 : 4); i++) begin
            if (!wrMask[i] || k == 4) mdl[i] = wrData[8*i +: 8];
            expD[8*i +: 8] = mdl[i];
         end
         req(dbw_pkg::CMD_WR, 3'h0, (k == 2 || k == 3) ? 14'h1000 : 14'h0000);
         expQ.push_back(expD);
         @(negedge clock);
         `CHK(busy, 1'b1)
         // Freeze both ends after the write command, before its first beat; the write must resume intact
         if (k == 1) begin
            clkEn = 1'b0;
            repeat (3) @(negedge clock);
            clkEn = 1'b1;
         end
         req(dbw_pkg::CMD_RD, 3'h0, (k == 2 || k == 3) ? 14'h1000 : 14'h0000);
      end
      `CHK(bankOpen, 8'h01)
      req(dbw_pkg::CMD_PRE, 3'h0, 14'h0000);
      n = 0;
      while ((expQ.size() > 0 || busy !== 1'b0 || bankOpen !== 8'h00) && n < 400) begin
         @(negedge clock);
         n++;
      end
      `CHK(n < 400, 1'b1)
      `CHK(fault, 1'b0)
      closeOut();
   end
endmodule : ddr3_burst_write_precharge_timing_tb_top
